// File: logic/ssl_pkg.sv
// package: constants for the synthesizer serial load port
package ssl_pkg;
  localparam int WORD_W = 32;
  localparam int SEL_W = 3;
  localparam int NUM_REGS = 6;
  localparam logic [2:0] SEL_FRAC_INT = 3'h0;
  localparam logic [2:0] SEL_LAST = 3'h5;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // power-down bit position inside register 2 word
  localparam int PD_BIT = 5;
  // diagnostic select field in register 2 word
  localparam int MUX_LO = 26;
  localparam int MUX_HI = 28;
  localparam logic [2:0] MUX_LOCK = 3'h6;
  localparam logic [2:0] MUX_RDIV = 3'h4;
  localparam logic [2:0] MUX_NDIV = 3'h3;
  localparam logic [2:0] PD_REG = 3'h2;
  // register 1 and 2 fields that are double buffered live in these words
  localparam logic [2:0] DB_REG_A = 3'h1;
  localparam logic [2:0] DB_REG_B = 3'h2;
endpackage : ssl_pkg

// File: logic/ssl_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module ssl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssl_sync_type;
  ssl_sync_type st;
  ssl_sync_type next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign q = st.s2;
endmodule : ssl_sync

// File: logic/ssl_top.sv
// synthesizer serial load port: shift register, latches and pin control
//
// Summary of operation
// (RL1) each rising serial clock edge shifts the data line into a 32-bit register
// (RL2) host sends most-significant bit first; last bits become the low bits
// (RL3) the three lowest bits pick the target latch, not payload
// (RL4) rising load strobe copies the shift word into the selected latch
// (RL5) chip-enable low forces power-down and pump output three-state
// (RL6) chip-enable high powers up only if the power-down bit allows
// (RL7) lock indicator is high while locked and powered up, low when lock is lost
// (RL8) diagnostic output shows lock detect, divided RF or divided reference
// (RL9) codes 000 to 101 select latches zero to five; others are ignored
// (RL10) double-buffered settings apply only after a later register zero write
// (RL11) only the last 32 bits before the strobe are kept
`timescale 1ns/1ps
module ssl_top #(
  parameter int WORD_W = ssl_pkg::WORD_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic chip_enable,
  input wire logic lock_raw,
  input wire logic rf_div_raw,
  input wire logic ref_div_raw,
  output logic lock_indicator,
  output logic diag_select_output,
  output logic pump_enable,
  output logic pump_output_oe_n,
  output logic powered_up,
  output logic [WORD_W-1:0] frac_int_word_reg,
  output logic [WORD_W-1:0] active_word_a,
  output logic [WORD_W-1:0] active_word_b,
  output logic [2:0] last_target
);

  // ----------------------------------------------------------------
  // local sizes
  // ----------------------------------------------------------------
  localparam int SEL_W = ssl_pkg::SEL_W;
  localparam int NUM_REGS = ssl_pkg::NUM_REGS;
  localparam int MUX_W = ssl_pkg::MUX_HI - ssl_pkg::MUX_LO + 1;
  // host pins and loop status arrive from clocks other than mclk
  localparam int CTL_W = 2;
  localparam int LOOP_W = 3;

  // ----------------------------------------------------------------
  // link domain: shift register on the serial clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] shift;
  } ssl_link_type;
  ssl_link_type lk;
  ssl_link_type next_lk;

  always_comb begin
    next_lk = lk;
    // old bits fall off the top [RL11]
    next_lk.shift = {lk.shift[WORD_W-2:0], sdata}; // [RL1] [RL2]
  end

  // serial clock stops between frames; reset is applied only while it is idle
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------
  // crossing into the core clock
  // ----------------------------------------------------------------
  // the word is not synchronised: the host keeps the serial clock still
  // while the strobe is high, so the word is quiet when it is taken
  logic [CTL_W-1:0] ctl_raw;
  logic [CTL_W-1:0] ctl_s;
  logic [LOOP_W-1:0] loop_raw;
  logic [LOOP_W-1:0] loop_s;
  logic strobe_s;
  logic ce_s;
  logic lock_s;
  logic rf_s;
  logic ref_s;

  assign ctl_raw = {load_strobe, chip_enable};
  assign {strobe_s, ce_s} = ctl_s;
  assign loop_raw = {lock_raw, rf_div_raw, ref_div_raw};
  assign {lock_s, rf_s, ref_s} = loop_s;

  // host pins: load strobe and chip enable
  ssl_sync #(
    .W(CTL_W)
  ) u_sync_ctl (
    .clk(mclk),
    .rstn(rstn),
    .d(ctl_raw),
    .q(ctl_s)
  );

  // loop status; divided clocks above half of mclk alias on the diag pin
  ssl_sync #(
    .W(LOOP_W)
  ) u_sync_loop (
    .clk(mclk),
    .rstn(rstn),
    .d(loop_raw),
    .q(loop_s)
  );

  // ----------------------------------------------------------------
  // core domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic strobe_d;
    logic [NUM_REGS-1:0][WORD_W-1:0] latch;
    logic [WORD_W-1:0] act_a;
    logic [WORD_W-1:0] act_b;
    logic [SEL_W-1:0] target;
    logic lock_o;
    logic diag_o;
    logic pump_en;
    logic pump_oe_n;
    logic pwr;
  } ssl_core_type;
  ssl_core_type cs;
  ssl_core_type next_cs;

  // ----------------------------------------------------------------
  // load detect and target decode
  // ----------------------------------------------------------------
  logic load_now;
  logic [SEL_W-1:0] sel;
  logic sel_ok;
  logic [NUM_REGS-1:0] latch_we;
  logic load_ok;
  logic frac_int_we;

  // strobe edge after the sync; a strobe held high loads only once
  assign load_now = strobe_s && !cs.strobe_d; // [RL4]
  assign sel = lk.shift[SEL_W-1:0]; // [RL3]
  assign sel_ok = (sel <= ssl_pkg::SEL_LAST); // [RL9]

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_latch_we
      // each latch answers to its own code only
      assign latch_we[gi] = load_now && sel_ok && (sel == SEL_W'(gi)); // [RL9]
    end
  endgenerate

  assign load_ok = |latch_we;
  assign frac_int_we = latch_we[ssl_pkg::SEL_FRAC_INT]; // [RL10]

  // ----------------------------------------------------------------
  // power, pump and diagnostic selection
  // ----------------------------------------------------------------
  logic pd_bit;
  logic pwr_ok;
  logic [MUX_W-1:0] mux_sel;

  // power-down bit is clear after reset, so a fresh part powers up with enable
  assign pd_bit = cs.latch[ssl_pkg::PD_REG][ssl_pkg::PD_BIT];
  assign pwr_ok = ce_s && !pd_bit; // [RL5] [RL6]
  assign mux_sel = cs.latch[ssl_pkg::PD_REG][ssl_pkg::MUX_HI:ssl_pkg::MUX_LO];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cs = cs;
    next_cs.strobe_d = strobe_s;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (latch_we[i]) begin
        next_cs.latch[i] = lk.shift; // [RL4] [RL11]
      end
    end
    if (load_ok) begin
      next_cs.target = sel;
    end
    // buffered words reach the active copies only on a latch zero write
    if (frac_int_we) begin
      next_cs.act_a = cs.latch[ssl_pkg::DB_REG_A]; // [RL10]
      next_cs.act_b = cs.latch[ssl_pkg::DB_REG_B]; // [RL10]
    end
    next_cs.pwr = pwr_ok; // [RL5] [RL6]
    next_cs.pump_en = pwr_ok; // [RL6]
    // high means three-state; the pump drives only while powered
    next_cs.pump_oe_n = !pwr_ok; // [RL5]
    // a powered-down loop never reports lock
    next_cs.lock_o = lock_s && pwr_ok; // [RL7]
    unique case (mux_sel) // [RL8]
      ssl_pkg::MUX_LOCK: next_cs.diag_o = lock_s;
      ssl_pkg::MUX_NDIV: next_cs.diag_o = rf_s;
      ssl_pkg::MUX_RDIV: next_cs.diag_o = ref_s;
      default: next_cs.diag_o = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs <= '0;
      cs.pump_oe_n <= 1'b1;
    end else begin
      cs <= next_cs;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------------------------------
  assign lock_indicator = cs.lock_o;
  assign diag_select_output = cs.diag_o;
  assign pump_enable = cs.pump_en;
  assign pump_output_oe_n = cs.pump_oe_n;
  assign powered_up = cs.pwr;
  assign frac_int_word_reg = cs.latch[ssl_pkg::SEL_FRAC_INT];
  assign active_word_a = cs.act_a;
  assign active_word_b = cs.act_b;
  assign last_target = cs.target;

endmodule : ssl_top

// File: tb/ssl_host.sv
// host model driving the serial load pins
`timescale 1ns/1ps
module ssl_host (
  output logic sclk,
  output logic sdata,
  output logic load_strobe
);
  initial {sclk, sdata, load_strobe} = 3'h0;
  task automatic send(input logic [35:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdata = w[i];
      #16 sclk = 1;
      #16 sclk = 0;
    end
    sdata = ~sdata; // released line shows no stale bit
    #16 load_strobe = 1;
    #400 load_strobe = 0; // held past the two-stage sync
    #400;
  endtask : send
endmodule : ssl_host

// File: tb/ssl_top_assertions.sv
// assertion checker for the serial load port
`timescale 1ns/1ps
module ssl_top_assertions #(parameter int WORD_W = 32) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic chip_enable,
  input wire logic lock_raw,
  input wire logic lock_indicator,
  input wire logic pump_enable,
  input wire logic pump_output_oe_n,
  input wire logic powered_up,
  input wire logic [WORD_W-1:0] frac_int_word_reg,
  input wire logic [WORD_W-1:0] active_word_a,
  input wire logic [2:0] last_target
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_ce_pd: assert property (!chip_enable [*5] |-> !powered_up)
    else $error("up while disabled");
  a_ce_tri: assert property (!chip_enable [*5] |-> pump_output_oe_n)
    else $error("pump driven");
  a_pump_off: assert property (!chip_enable [*5] |-> !pump_enable)
    else $error("pump on");
  a_ld_off: assert property (!powered_up [*5] |-> !lock_indicator)
    else $error("lock while down");
  a_ld_on: assert property ((lock_raw && powered_up) [*5] |-> lock_indicator)
    else $error("lock missing");
  a_reg0_sel: assert property ($changed(frac_int_word_reg) |->
    last_target == 3'h0 && frac_int_word_reg[2:0] == 3'h0)
    else $error("bad latch zero load");
  a_db_copy: assert property ($changed(active_word_a) |-> last_target == 3'h0)
    else $error("early copy");
  a_tgt_rng: assert property (last_target <= 3'h5)
    else $error("bad target");
endmodule : ssl_top_assertions
bind ssl_top ssl_top_assertions #(
  .WORD_W(WORD_W)
) u_chk (
  .mclk(mclk),
  .rstn(rstn),
  .chip_enable(chip_enable),
  .lock_raw(lock_raw),
  .lock_indicator(lock_indicator),
  .pump_enable(pump_enable),
  .pump_output_oe_n(pump_output_oe_n),
  .powered_up(powered_up),
  .frac_int_word_reg(frac_int_word_reg),
  .active_word_a(active_word_a),
  .last_target(last_target)
);

// File: tb/ssl_top_tb.sv
// testbench for the serial load port
`timescale 1ns/1ps
module ssl_top_tb;
  logic mclk = 0, rstn = 0, chip_enable = 1, lock_raw = 0, rf_div_raw = 0, ref_div_raw = 0;
  logic sclk, sdata, load_strobe, lock_indicator, diag_select_output, pump_enable;
  logic pump_output_oe_n, powered_up;
  logic [31:0] frac_int_word_reg, active_word_a, active_word_b;
  logic [2:0] last_target;
  int n_fail = 0, n_tests = 0;
  always #50 mclk = ~mclk;
  ssl_top dut (
    .mclk(mclk),
    .rstn(rstn),
    .sclk(sclk),
    .sdata(sdata),
    .load_strobe(load_strobe),
    .chip_enable(chip_enable),
    .lock_raw(lock_raw),
    .rf_div_raw(rf_div_raw),
    .ref_div_raw(ref_div_raw),
    .lock_indicator(lock_indicator),
    .diag_select_output(diag_select_output),
    .pump_enable(pump_enable),
    .pump_output_oe_n(pump_output_oe_n),
    .powered_up(powered_up),
    .frac_int_word_reg(frac_int_word_reg),
    .active_word_a(active_word_a),
    .active_word_b(active_word_b),
    .last_target(last_target)
  );
  ssl_host u_host (
    .sclk(sclk),
    .sdata(sdata),
    .load_strobe(load_strobe)
  );
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic t_load;
    u_host.send({4'hF, 32'h1234_5670}, 36);
    chk("w0", frac_int_word_reg, 32'h1234_5670);
    u_host.send(36'h0_0000_AB01, 32);
    chk("tgt", last_target, 3'h1);
    chk("a", active_word_a, 32'h0);
    u_host.send(36'h0_0000_0008, 32);
    chk("a", active_word_a, 32'h0000_AB01);
    u_host.send(36'h0_FFFF_FFF6, 32);
    chk("tgt", last_target, 3'h0);
    chk("w0", frac_int_word_reg, 32'h8);
  endtask : t_load
  task automatic t_power;
    logic [31:0] mux[3] = '{32'h1800_0002, 32'h0C00_0002, 32'h1000_0002};
    @(negedge mclk);
    chip_enable = 0;
    repeat (6) @(negedge mclk);
    chk("pu", powered_up, 0);
    chk("oe", pump_output_oe_n, 1);
    chk("pe", pump_enable, 0);
    chip_enable = 1;
    u_host.send(36'h0_0000_0022, 32);
    chk("pu", powered_up, 0);
    for (int i = 0; i < 3; i++) begin
      u_host.send({4'h0, mux[i]}, 32);
      @(negedge mclk);
      {lock_raw, rf_div_raw, ref_div_raw} = 3'h4 >> i;
      repeat (6) @(negedge mclk);
      chk("pu", powered_up, 1);
      chk("ld", lock_indicator, i == 0);
      chk("mux", diag_select_output, 1);
      chk("oe", pump_output_oe_n, 0);
      chk("pe", pump_enable, 1);
      @(negedge mclk);
      {lock_raw, rf_div_raw, ref_div_raw} = 3'h0;
      repeat (6) @(negedge mclk);
      chk("mux", diag_select_output, 0);
      chk("ld", lock_indicator, 0);
    end
  endtask : t_power
  task automatic t_dbuf;
    chk("b", active_word_b, 32'h0);
    u_host.send(36'h0_0000_0010, 32);
    chk("b", active_word_b, 32'h1000_0002);
    chk("a", active_word_a, 32'h0000_AB01);
    chk("w0", frac_int_word_reg, 32'h0000_0010);
  endtask : t_dbuf
  task automatic t_reset;
    @(negedge mclk);
    rstn = 0;
    @(negedge mclk);
    chk("w0", frac_int_word_reg, 32'h0);
    chk("tgt", last_target, 32'h0);
    chk("oe", pump_output_oe_n, 32'h1);
    chk("pu", powered_up, 32'h0);
    rstn = 1;
    repeat (6) @(negedge mclk);
    chk("pu", powered_up, 32'h1);
    chk("oe", pump_output_oe_n, 32'h0);
  endtask : t_reset
  initial begin
    repeat (20) @(negedge mclk);
    rstn = 1;
    repeat (3) @(negedge mclk);
    t_load;
    t_power;
    t_dbuf;
    t_reset;
    tally_and_finish;
  end
  initial begin
    #300000;
    n_fail++;
    tally_and_finish;
  end
endmodule : ssl_top_tb
